//--- design/tmr2_timer.sv
// Sixteen-bit timer/counter with up/down reload, capture and clock output.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "tmr2_consts.svh"
module tmr2_timer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire tmr2_pkg::tmr2_bus_req_t bus_req,
	output logic [7:0] rdata,
	input wire tmr2_pkg::tmr2_pins_in_t pins_in,
	output tmr2_pkg::tmr2_pins_out_t pins_out,
	output logic irq,
	output logic baud_tick
);
	logic [7:0] ctrl_reg;
	logic [1:0] mode_reg;
	logic [7:0] cnt_lo_reg;
	logic [7:0] cnt_hi_reg;
	logic [7:0] rld_lo_reg;
	logic [7:0] rld_hi_reg;
	logic [2:0] t_sync_reg;
	logic [2:0] d_sync_reg;
	logic t_state_reg;
	logic d_state_reg;
	logic [3:0] pre_reg;
	logic half_reg;
	logic clk_out_reg;
	logic t_fall;
	logic d_fall;
	logic dir_up;
	logic tick;
	logic wrap_up;
	logic wrap_dn;
	logic ext_evt;
	logic ovf_any;
	logic [15:0] cnt;
	logic [15:0] rld;
	logic [15:0] cnt_next;
	tmr2_pkg::tmr2_mode_t mode;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction : hit

	assign cnt = {cnt_hi_reg, cnt_lo_reg};
	assign rld = {rld_hi_reg, rld_lo_reg};

	// Filtered pin state changes only when the second and third stages agree.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			t_sync_reg <= 3'h7;
			d_sync_reg <= 3'h7;
			t_state_reg <= 1'b1;
			d_state_reg <= 1'b1;
		end
		else if (clk_en)
		begin
			t_sync_reg <= {t_sync_reg[1:0], pins_in.count_in};
			d_sync_reg <= {d_sync_reg[1:0], pins_in.dir_trig};
			if (t_sync_reg[1] == t_sync_reg[2])
				t_state_reg <= t_sync_reg[2];
			if (d_sync_reg[1] == d_sync_reg[2])
				d_state_reg <= d_sync_reg[2];
		end
	end

	assign t_fall = t_state_reg && (t_sync_reg[1] == t_sync_reg[2]) && !t_sync_reg[2];
	assign d_fall = d_state_reg && (d_sync_reg[1] == d_sync_reg[2]) && !d_sync_reg[2];
	assign dir_up = d_state_reg;

	always_comb
	begin
		if (ctrl_reg[`TMR2_BIT_RXSEL] || ctrl_reg[`TMR2_BIT_TXSEL])
			mode = tmr2_pkg::TMR2_MODE_BAUD;
		else if (ctrl_reg[`TMR2_BIT_CPRL])
			mode = tmr2_pkg::TMR2_MODE_CAPTURE;
		else
			mode = tmr2_pkg::TMR2_MODE_RELOAD;
	end

	// Prescaler for timer operation and the half-rate clock-output tick.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_reg <= 4'h0;
			half_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (pre_reg == `TMR2_TIMER_DIV - 4'd1)
				pre_reg <= 4'h0;
			else
				pre_reg <= pre_reg + 4'd1;
			half_reg <= half_reg ^ `TMR2_CLKOUT_DIV;
		end
	end

	always_comb
	begin
		if (!ctrl_reg[`TMR2_BIT_RUN])
			tick = 1'b0;
		else if (mode_reg[`TMR2_BIT_OE] || mode == tmr2_pkg::TMR2_MODE_BAUD)
			tick = half_reg;
		else if (ctrl_reg[`TMR2_BIT_CT])
			tick = t_fall;
		else
			tick = (pre_reg == `TMR2_TIMER_DIV - 4'd1);
	end

	logic updown;
	assign updown = mode_reg[`TMR2_BIT_UPDN] && (mode == tmr2_pkg::TMR2_MODE_RELOAD);
	assign wrap_up = tick && (!updown || dir_up) && (cnt == `TMR2_ALL_ONES);
	assign wrap_dn = tick && updown && !dir_up && hit(cnt_hi_reg, rld_hi_reg)
		&& hit(cnt_lo_reg, rld_lo_reg);
	assign ext_evt = d_fall && ctrl_reg[`TMR2_BIT_EXEN] && !updown;
	assign ovf_any = wrap_up || wrap_dn;

	always_comb
	begin
		cnt_next = cnt;
		if (wrap_dn)
			cnt_next = `TMR2_ALL_ONES;
		else if (wrap_up)
		begin
			if (mode != tmr2_pkg::TMR2_MODE_CAPTURE || mode_reg[`TMR2_BIT_OE] || updown)
				cnt_next = rld;
			else
				cnt_next = 16'h0000;
		end
		else if (tick && updown && !dir_up)
			cnt_next = cnt - 16'h0001;
		else if (tick)
			cnt_next = cnt + 16'h0001;
		if (ext_evt && mode == tmr2_pkg::TMR2_MODE_RELOAD)
			cnt_next = rld;
	end

	// Count bytes; a software write replaces the written count byte this cycle.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_lo_reg <= 8'h00;
			cnt_hi_reg <= 8'h00;
		end
		else if (clk_en)
		begin
			cnt_lo_reg <= cnt_next[7:0];
			cnt_hi_reg <= cnt_next[15:8];
			if (bus_req.wr && bus_req.addr == `TMR2_ADDR_CNT_LO)
				cnt_lo_reg <= bus_req.wdata;
			else if (bus_req.wr && bus_req.addr == `TMR2_ADDR_CNT_HI)
				cnt_hi_reg <= bus_req.wdata;
		end
	end

	// Reload bytes double as capture registers in capture mode.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rld_lo_reg <= 8'h00;
			rld_hi_reg <= 8'h00;
		end
		else if (clk_en)
		begin
			if (ext_evt && mode == tmr2_pkg::TMR2_MODE_CAPTURE)
			begin
				rld_lo_reg <= cnt_lo_reg;
				rld_hi_reg <= cnt_hi_reg;
			end
			else if (bus_req.wr && bus_req.addr == `TMR2_ADDR_RLD_LO)
				rld_lo_reg <= bus_req.wdata;
			else if (bus_req.wr && bus_req.addr == `TMR2_ADDR_RLD_HI)
				rld_hi_reg <= bus_req.wdata;
		end
	end

	// Flags: a hardware set wins over a software clear in the same cycle.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_reg <= `TMR2_CTRL_RESET;
		else if (clk_en)
		begin
			if (bus_req.wr && bus_req.addr == `TMR2_ADDR_CTRL)
				ctrl_reg <= bus_req.wdata;
			if (ovf_any && !ctrl_reg[`TMR2_BIT_RXSEL] && !ctrl_reg[`TMR2_BIT_TXSEL])
				ctrl_reg[`TMR2_BIT_OVF] <= 1'b1;
			if (updown && ovf_any)
				ctrl_reg[`TMR2_BIT_EXF] <= !ctrl_reg[`TMR2_BIT_EXF];
			else if (ext_evt)
				ctrl_reg[`TMR2_BIT_EXF] <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			mode_reg <= `TMR2_MODE_RESET;
		else if (clk_en && bus_req.wr && bus_req.addr == `TMR2_ADDR_MODE)
			mode_reg <= bus_req.wdata[1:0];
	end

	// Output toggles on each upward overflow (wrap_up), not on an underflow, giving an even duty cycle.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			clk_out_reg <= 1'b0;
		else if (clk_en && mode_reg[`TMR2_BIT_OE] && wrap_up)
			clk_out_reg <= !clk_out_reg;
	end

	assign pins_out.clk_out = clk_out_reg;
	assign pins_out.clk_oe = mode_reg[`TMR2_BIT_OE];
	// The overflow flag interrupts only when clock output is off; the external flag only when up/down is off.
	assign irq = (ctrl_reg[`TMR2_BIT_OVF] && !mode_reg[`TMR2_BIT_OE])
		|| (ctrl_reg[`TMR2_BIT_EXF] && !mode_reg[`TMR2_BIT_UPDN]);
	assign baud_tick = wrap_up && (mode == tmr2_pkg::TMR2_MODE_BAUD);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (clk_en && bus_req.rd)
		begin
			if (bus_req.addr == `TMR2_ADDR_CTRL)
				rdata <= ctrl_reg;
			else if (bus_req.addr == `TMR2_ADDR_MODE)
				rdata <= {6'h00, mode_reg};
			else if (bus_req.addr == `TMR2_ADDR_RLD_LO)
				rdata <= rld_lo_reg;
			else if (bus_req.addr == `TMR2_ADDR_RLD_HI)
				rdata <= rld_hi_reg;
			else if (bus_req.addr == `TMR2_ADDR_CNT_LO)
				rdata <= cnt_lo_reg;
			else if (bus_req.addr == `TMR2_ADDR_CNT_HI)
				rdata <= cnt_hi_reg;
			else
				rdata <= 8'h00;
		end
	end

	chk_up_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && wrap_up && mode == tmr2_pkg::TMR2_MODE_RELOAD && !bus_req.wr
		|=> cnt == $past(rld))
		else $error("reload not loaded on overflow");

	chk_under_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && wrap_dn && !bus_req.wr |=> cnt == 16'hffff)
		else $error("underflow did not load all ones");

	chk_ovf_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && ovf_any && !ctrl_reg[`TMR2_BIT_RXSEL] && !ctrl_reg[`TMR2_BIT_TXSEL]
		|=> ctrl_reg[`TMR2_BIT_OVF])
		else $error("overflow flag not set");

	chk_run_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !ctrl_reg[`TMR2_BIT_RUN] && !bus_req.wr && !ext_evt |=> $stable(cnt))
		else $error("count moved while stopped");

	chk_exf_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && updown && ovf_any && !bus_req.wr
		|=> ctrl_reg[`TMR2_BIT_EXF] != $past(ctrl_reg[`TMR2_BIT_EXF]))
		else $error("external flag did not toggle");

	chk_clk_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && mode_reg[`TMR2_BIT_OE] && wrap_up
		|=> pins_out.clk_out != $past(pins_out.clk_out))
		else $error("clock output did not toggle");

	chk_clkout_noirq: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_reg[`TMR2_BIT_OE] && (!ctrl_reg[`TMR2_BIT_EXF] || mode_reg[`TMR2_BIT_UPDN])
		|-> !irq)
		else $error("interrupt in clock-output mode");

	chk_oe_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && bus_req.wr && bus_req.addr == `TMR2_ADDR_MODE
		|=> pins_out.clk_oe == $past(bus_req.wdata[1]))
		else $error("output enable not following mode");

	chk_carry_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && tick && !ovf_any && !ext_evt && !bus_req.wr && (!updown || dir_up)
		|=> cnt == $past(cnt) + 16'h0001)
		else $error("count did not step up");

	chk_down_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && tick && updown && !dir_up && !ovf_any && !bus_req.wr
		|=> cnt == $past(cnt) - 16'h0001)
		else $error("count did not step down");

	chk_ovf_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_reg[`TMR2_BIT_OVF] && !(bus_req.wr && bus_req.addr == `TMR2_ADDR_CTRL)
		|=> ctrl_reg[`TMR2_BIT_OVF])
		else $error("overflow flag cleared by hardware");

	chk_ovf_baud_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ctrl_reg[`TMR2_BIT_RXSEL] || ctrl_reg[`TMR2_BIT_TXSEL]) && !ctrl_reg[`TMR2_BIT_OVF]
		&& !(bus_req.wr && bus_req.addr == `TMR2_ADDR_CTRL) |=> !ctrl_reg[`TMR2_BIT_OVF])
		else $error("overflow flag set in baud mode");

	chk_ext_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && ext_evt |=> ctrl_reg[`TMR2_BIT_EXF])
		else $error("external flag not set on trigger");

	chk_trig_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && ext_evt && mode == tmr2_pkg::TMR2_MODE_RELOAD && !bus_req.wr
		|=> cnt == $past(rld))
		else $error("trigger did not reload the count");

	chk_capture_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && ext_evt && mode == tmr2_pkg::TMR2_MODE_CAPTURE |=> rld == $past(cnt))
		else $error("trigger did not capture the count");

	chk_baud_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && wrap_up && mode == tmr2_pkg::TMR2_MODE_BAUD && !bus_req.wr
		|=> cnt == $past(rld))
		else $error("baud overflow did not reload");

	chk_updown_noirq: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_reg[`TMR2_BIT_UPDN] && !ctrl_reg[`TMR2_BIT_OVF] |-> !irq)
		else $error("external flag interrupted in up/down mode");

	chk_ext_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_reg[`TMR2_BIT_EXF] && !mode_reg[`TMR2_BIT_UPDN] |-> irq)
		else $error("external flag raised no interrupt");

	chk_ovf_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_reg[`TMR2_BIT_OVF] && !mode_reg[`TMR2_BIT_OE] |-> irq)
		else $error("overflow flag raised no interrupt");

	chk_clk_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(clk_en && mode_reg[`TMR2_BIT_OE] && wrap_up) |=> $stable(pins_out.clk_out))
		else $error("clock output moved without overflow");

	chk_read_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && bus_req.rd && bus_req.addr == `TMR2_ADDR_CNT_LO
		|=> rdata == $past(cnt_lo_reg))
		else $error("count read returned wrong byte");

	chk_write_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && bus_req.wr && bus_req.addr == `TMR2_ADDR_CNT_HI
		|=> cnt_hi_reg == $past(bus_req.wdata))
		else $error("count write did not land");

	chk_mode_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && bus_req.wr && bus_req.addr == `TMR2_ADDR_MODE
		|=> mode_reg == $past(bus_req.wdata[1:0]))
		else $error("mode write did not land");

	chk_mode_onehot: assert property (@(posedge core_clk) disable iff (!rst_n)
		$onehot(mode))
		else $error("operating mode not one-hot");

	chk_prescale_range: assert property (@(posedge core_clk) disable iff (!rst_n)
		pre_reg < `TMR2_TIMER_DIV)
		else $error("prescaler out of range");

	chk_prescale_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && pre_reg == `TMR2_TIMER_DIV - 4'd1 |=> pre_reg == 4'h0)
		else $error("prescaler did not wrap");

	chk_tick_stopped: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ctrl_reg[`TMR2_BIT_RUN] |-> !tick)
		else $error("tick while stopped");

	chk_half_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_reg[`TMR2_BIT_RUN] && mode_reg[`TMR2_BIT_OE] |-> tick == half_reg)
		else $error("clock-output tick not at half rate");

	chk_counter_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_reg[`TMR2_BIT_RUN] && ctrl_reg[`TMR2_BIT_CT] && !mode_reg[`TMR2_BIT_OE]
		&& mode != tmr2_pkg::TMR2_MODE_BAUD |-> tick == t_fall)
		else $error("counter tick not from pin edge");

	chk_pin_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && t_fall |=> !t_state_reg)
		else $error("count pin state did not follow edge");

	chk_trig_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && d_fall |=> !d_state_reg)
		else $error("trigger pin state did not follow edge");

	// A low enable must freeze every register, bus writes included.
	chk_freeze_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!clk_en |=> $stable(cnt) && $stable(rld) && $stable(ctrl_reg) && $stable(mode_reg))
		else $error("state moved while frozen");

	cov_up_wrap: cover property (@(posedge core_clk) disable iff (!rst_n) wrap_up);
	cov_dn_wrap: cover property (@(posedge core_clk) disable iff (!rst_n) wrap_dn);
	cov_ext: cover property (@(posedge core_clk) disable iff (!rst_n) ext_evt);
	cov_clk_toggle: cover property (@(posedge core_clk) disable iff (!rst_n)
		mode_reg[`TMR2_BIT_OE] && wrap_up);
	cov_capture: cover property (@(posedge core_clk) disable iff (!rst_n)
		ext_evt && mode == tmr2_pkg::TMR2_MODE_CAPTURE);
endmodule : tmr2_timer

//--- design/tmr2_consts.svh
// Constants for the sixteen-bit reloadable timer with clock output.
`ifndef TMR2_CONSTS_SVH
`define TMR2_CONSTS_SVH
`define TMR2_ADDR_CTRL 8'hc8
`define TMR2_ADDR_MODE 8'hc9
`define TMR2_ADDR_RLD_LO 8'hca
`define TMR2_ADDR_RLD_HI 8'hcb
`define TMR2_ADDR_CNT_LO 8'hcc
`define TMR2_ADDR_CNT_HI 8'hcd
`define TMR2_CTRL_RESET 8'h00
`define TMR2_MODE_RESET 2'h0
`define TMR2_BIT_OVF 7
`define TMR2_BIT_EXF 6
`define TMR2_BIT_RXSEL 5
`define TMR2_BIT_TXSEL 4
`define TMR2_BIT_EXEN 3
`define TMR2_BIT_RUN 2
`define TMR2_BIT_CT 1
`define TMR2_BIT_CPRL 0
`define TMR2_BIT_OE 1
`define TMR2_BIT_UPDN 0
`define TMR2_TIMER_DIV 4'd12
`define TMR2_CLKOUT_DIV 1'b1
`define TMR2_ALL_ONES 16'hffff
`endif

//--- design/tmr2_pkg.sv
// Types shared by the timer and its surroundings.
package tmr2_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tmr2_bus_req_t;
	typedef struct packed {
		logic count_in;
		logic dir_trig;
	} tmr2_pins_in_t;
	typedef struct packed {
		logic clk_out;
		logic clk_oe;
	} tmr2_pins_out_t;
	typedef enum logic [2:0] {
		TMR2_MODE_CAPTURE = 3'b001,
		TMR2_MODE_RELOAD = 3'b010,
		TMR2_MODE_BAUD = 3'b100
	} tmr2_mode_t;
endpackage : tmr2_pkg

//--- testbench/test_timer2_updown_clockout.sv
// Self-checking bench for the sixteen-bit reloadable timer.
`timescale 1ns/1ns
`include "tmr2_consts.svh"
module test_timer2_updown_clockout;
	logic core_clk;
	logic rst_n;
	logic clk_en;
	tmr2_pkg::tmr2_bus_req_t bus_req;
	tmr2_pkg::tmr2_pins_in_t pins_in;
	tmr2_pkg::tmr2_pins_out_t pins_out;
	logic [7:0] rdata;
	logic irq;
	logic baud_tick;
	int fail_count;
	int n_compared;
	tmr2_timer tmr2_timer_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.bus_req(bus_req),
		.rdata(rdata),
		.pins_in(pins_in),
		.pins_out(pins_out),
		.irq(irq),
		.baud_tick(baud_tick)
	);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd
	// Low and high bytes sit at adjacent offsets for both count and reload.
	task automatic set16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask : set16
	task automatic cnt(output logic [15:0] v);
		rd(`TMR2_ADDR_CNT_LO, v[7:0]);
		rd(`TMR2_ADDR_CNT_HI, v[15:8]);
	endtask : cnt
	task automatic wait_ctl(input int b);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 300 && v[b] !== 1'b1; i++)
			rd(`TMR2_ADDR_CTRL, v);
		if (v[b] !== 1'b1)
		begin
			fail_count++;
			$display("wrong value control bit %0d expected 1 seen 0", b);
			conclude();
		end
	endtask : wait_ctl
	task automatic t_regs;
		logic [7:0] v;
		logic [15:0] w;
		rd(`TMR2_ADDR_CTRL, v);
		chk("control", 16'(`TMR2_CTRL_RESET), 16'(v));
		rd(`TMR2_ADDR_MODE, v);
		chk("mode", 16'(`TMR2_MODE_RESET), 16'(v[1:0]));
		wr(8'hc0, 8'h5a);
		rd(8'hc0, v);
		chk("unmapped", 16'h0000, 16'(v));
		set16(`TMR2_ADDR_RLD_LO, 16'h1200);
		set16(`TMR2_ADDR_CNT_LO, 16'ha55a);
		cnt(w);
		chk("count", 16'ha55a, w);
		clk_en <= 1'b0;
		wr(`TMR2_ADDR_CNT_LO, 8'h77);
		clk_en <= 1'b1;
		rd(`TMR2_ADDR_CNT_LO, v);
		chk("frozen write", 16'h005a, 16'(v));
		rd(`TMR2_ADDR_RLD_HI, v);
		chk("reload high", 16'h0012, 16'(v));
		$display("test registers done");
	endtask : t_regs
	task automatic t_up;
		logic [15:0] v;
		logic [15:0] w;
		set16(`TMR2_ADDR_CNT_LO, 16'h00ff);
		wr(`TMR2_ADDR_CTRL, 8'h04);
		repeat (30) @(posedge core_clk);
		wr(`TMR2_ADDR_CTRL, 8'h00);
		cnt(v);
		chk("carry", 16'h0001, 16'(v[15:8]));
		set16(`TMR2_ADDR_CNT_LO, 16'hfffe);
		wr(`TMR2_ADDR_CTRL, 8'h04);
		wait_ctl(`TMR2_BIT_OVF);
		chk("irq", 16'h0001, 16'(irq));
		wr(`TMR2_ADDR_CTRL, 8'h00);
		cnt(v);
		chk("reloaded", 16'h0012, 16'(v[15:8]));
		chk("irq", 16'h0000, 16'(irq));
		repeat (50) @(posedge core_clk);
		cnt(w);
		chk("held", v, w);
		$display("test up count done");
	endtask : t_up
	task automatic t_updown;
		logic [15:0] v;
		logic [7:0] c;
		pins_in.dir_trig <= 1'b0;
		wr(`TMR2_ADDR_MODE, 8'h01);
		set16(`TMR2_ADDR_CNT_LO, 16'h1202);
		wr(`TMR2_ADDR_CTRL, 8'h04);
		wait_ctl(`TMR2_BIT_OVF);
		rd(`TMR2_ADDR_CTRL, c);
		chk("ext flag", 16'h00c4, 16'(c));
		wr(`TMR2_ADDR_CTRL, 8'h40);
		cnt(v);
		chk("underflow load", 16'h00ff, 16'(v[15:8]));
		chk("irq", 16'h0000, 16'(irq));
		pins_in.dir_trig <= 1'b1;
		set16(`TMR2_ADDR_CNT_LO, 16'hfffe);
		wr(`TMR2_ADDR_CTRL, 8'h44);
		wait_ctl(`TMR2_BIT_OVF);
		rd(`TMR2_ADDR_CTRL, c);
		chk("ext toggle", 16'h0084, 16'(c));
		wr(`TMR2_ADDR_CTRL, 8'h00);
		cnt(v);
		chk("up reload", 16'h0012, 16'(v[15:8]));
		wr(`TMR2_ADDR_MODE, 8'h00);
		$display("test up down done");
	endtask : t_updown
	task automatic t_counter;
		logic [15:0] v;
		set16(`TMR2_ADDR_CNT_LO, 16'h0000);
		wr(`TMR2_ADDR_CTRL, 8'h06);
		repeat (3)
		begin
			repeat (6) @(posedge core_clk);
			pins_in.count_in <= 1'b0;
			repeat (6) @(posedge core_clk);
			pins_in.count_in <= 1'b1;
		end
		repeat (6) @(posedge core_clk);
		wr(`TMR2_ADDR_CTRL, 8'h00);
		cnt(v);
		chk("pin count", 16'h0003, v);
		$display("test counter done");
	endtask : t_counter
	// The trigger edge must reload the count and flag it, then capture the count in capture mode, with the timer stopped.
	task automatic t_trig;
		logic [15:0] v;
		logic [7:0] c;
		set16(`TMR2_ADDR_RLD_LO, 16'h3400);
		set16(`TMR2_ADDR_CNT_LO, 16'h0000);
		wr(`TMR2_ADDR_CTRL, 8'h08);
		pins_in.dir_trig <= 1'b0;
		repeat (10) @(posedge core_clk);
		rd(`TMR2_ADDR_CTRL, c);
		chk("trigger flag", 16'h0048, 16'(c));
		chk("irq", 16'h0001, 16'(irq));
		cnt(v);
		chk("trigger load", 16'h3400, v);
		wr(`TMR2_ADDR_CTRL, 8'h00);
		pins_in.dir_trig <= 1'b1;
		set16(`TMR2_ADDR_CNT_LO, 16'h5678);
		wr(`TMR2_ADDR_CTRL, 8'h09);
		repeat (6) @(posedge core_clk);
		pins_in.dir_trig <= 1'b0;
		repeat (10) @(posedge core_clk);
		rd(`TMR2_ADDR_RLD_LO, v[7:0]);
		rd(`TMR2_ADDR_RLD_HI, v[15:8]);
		chk("capture", 16'h5678, v);
		wr(`TMR2_ADDR_CTRL, 8'h00);
		pins_in.dir_trig <= 1'b1;
		$display("test trigger done");
	endtask : t_trig
	task automatic t_clkout;
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		wr(`TMR2_ADDR_MODE, 8'h02);
		set16(`TMR2_ADDR_RLD_LO, 16'hfffe);
		set16(`TMR2_ADDR_CNT_LO, 16'hfffe);
		wr(`TMR2_ADDR_CTRL, 8'h04);
		for (int i = 0; i < 50 && pins_out.clk_out !== 1'b0; i++)
			@(negedge core_clk);
		for (int i = 0; i < 50 && pins_out.clk_out !== 1'b1; i++)
			@(negedge core_clk);
		while (hi < 20 && pins_out.clk_out === 1'b1)
		begin
			@(negedge core_clk);
			hi++;
		end
		while (lo < 20 && pins_out.clk_out === 1'b0)
		begin
			@(negedge core_clk);
			lo++;
		end
		chk("high time", 16'h0004, 16'(hi));
		chk("period", 16'h0008, 16'(hi + lo));
		chk("output enable", 16'h0001, 16'(pins_out.clk_oe));
		chk("irq", 16'h0000, 16'(irq));
		wr(`TMR2_ADDR_CTRL, 8'h00);
		wr(`TMR2_ADDR_MODE, 8'h00);
		$display("test clock output done");
	endtask : t_clkout
	task automatic t_baud;
		logic [7:0] c;
		logic seen;
		seen = 1'b0;
		set16(`TMR2_ADDR_RLD_LO, 16'hfff0);
		set16(`TMR2_ADDR_CNT_LO, 16'hfff0);
		wr(`TMR2_ADDR_CTRL, 8'h25);
		for (int i = 0; i < 200 && !seen; i++)
		begin
			@(negedge core_clk);
			seen = (baud_tick === 1'b1);
		end
		chk("baud tick", 16'h0001, 16'(seen));
		rd(`TMR2_ADDR_CTRL, c);
		chk("no overflow flag", 16'h0025, 16'(c));
		rd(`TMR2_ADDR_CNT_HI, c);
		chk("baud reload", 16'h00ff, 16'(c));
		wr(`TMR2_ADDR_CTRL, 8'h00);
		$display("test baud done");
	endtask : t_baud
	initial
	begin
		repeat (100000) @(posedge core_clk);
		fail_count++;
		conclude();
	end
	initial
	begin
		fail_count = 0;
		n_compared = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		bus_req = '0;
		pins_in = '{count_in: 1'b1, dir_trig: 1'b1};
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs();
		t_up();
		t_updown();
		t_counter();
		t_trig();
		t_clkout();
		t_baud();
		conclude();
	end
endmodule : test_timer2_updown_clockout
